// >>> include/stpe_pkg.sv
package stpe_pkg;

  // Widths
  localparam int STPE_DATA_W = 16;
  localparam int STPE_SYM_W  = 10;
  localparam int STPE_WORD_W = 20;

  // Serial bits per reference clock period; the core clock runs at the bit rate
  localparam logic [4:0] STPE_BIT_LAST  = 5'h13;
  localparam logic [4:0] STPE_BIT_FIRST = 5'h00;

  // Reset values
  localparam logic STPE_RD_RESET = 1'b0;
  localparam logic STPE_BIT_IDLE = 1'b0;

  // 8b/10b code points
  localparam logic [4:0] STPE_X_K28  = 5'h1C;
  localparam logic [4:0] STPE_X_D7   = 5'h07;
  localparam logic [2:0] STPE_Y_7    = 3'h7;
  localparam logic [5:0] STPE_6B_K28 = 6'h0F;
  localparam logic [3:0] STPE_4B_A7N = 4'h7;
  localparam logic [3:0] STPE_4B_A7P = 4'h8;
  localparam logic [3:0] STPE_4B_P7N = 4'hE;
  localparam logic [3:0] STPE_4B_P7P = 4'h1;

  // 5b/6b codes for negative disparity, abcdei with a in the MSB
  localparam logic [5:0] STPE_6B_TBL [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};

  // 3b/4b data codes for negative disparity, fghj with f in the MSB
  localparam logic [3:0] STPE_4B_TBL [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  // 4b tails of K28.y when the symbol starts at negative disparity
  localparam logic [3:0] STPE_4B_K28 [8] = '{
    4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'hA, 4'h6, 4'h8};

  // Parallel word as taken from the protocol device
  typedef struct packed {
    logic                   hi_ctrl;
    logic                   lo_ctrl;
    logic [STPE_DATA_W-1:0] data;
  } stpe_tx_word_t;

  localparam stpe_tx_word_t STPE_WORD_RESET = '0;

  function automatic logic [3:0] stpe_ones(input logic [STPE_SYM_W-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < STPE_SYM_W; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

endpackage

// >>> core/stpe_enc8b10b.sv
`timescale 1ns/100ps
`default_nettype none

module stpe_enc8b10b
  import stpe_pkg::*;
(
  // Byte to encode
  input  wire logic [7:0]            byte_in,
  input  wire logic                  ctrl_in,
  input  wire logic                  rd_in,
  // Symbol abcdeifghj, a in the MSB
  output logic [STPE_SYM_W-1:0]      sym_out,
  output logic                       rd_out,
  output logic                       ctrl_bad_out
);

  logic [4:0] x;
  logic [2:0] y;
  logic       k28;
  logic       k_alt;
  logic [5:0] s6;
  logic [3:0] s4;
  logic       rd_mid;
  logic [3:0] n6;

  always_comb begin
    x = byte_in[4:0];
    y = byte_in[7:5];
    k28 = ctrl_in && (x == STPE_X_K28);
    k_alt = ctrl_in && (y == STPE_Y_7) &&
            (x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E);
    // Unknown control byte falls back to its data code, so the line never stalls
    ctrl_bad_out = ctrl_in && !k28 && !k_alt;
    s6 = k28 ? STPE_6B_K28 : STPE_6B_TBL[x];
    n6 = stpe_ones({4'h0, s6});
    // Neutral 6b codes keep their form, except D.7 which has two
    if (rd_in && (k28 || n6 != 4'h3 || x == STPE_X_D7)) begin
      s6 = ~s6;
    end
    rd_mid = (n6 == 4'h3) ? rd_in : ~rd_in;
    if (k28) begin
      s4 = rd_in ? ~STPE_4B_K28[y] : STPE_4B_K28[y];
    end else if (k_alt) begin
      s4 = rd_mid ? STPE_4B_A7P : STPE_4B_A7N;
    end else if (y == STPE_Y_7) begin
      // Alternate form avoids a run of five equal bits
      if ((!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
          (rd_mid && (x == 5'h0B || x == 5'h0D || x == 5'h0E))) begin
        s4 = rd_mid ? STPE_4B_A7P : STPE_4B_A7N;
      end else begin
        s4 = rd_mid ? STPE_4B_P7P : STPE_4B_P7N;
      end
    end else begin
      s4 = STPE_4B_TBL[y];
      if (rd_mid && !(y == 3'h1 || y == 3'h2 || y == 3'h5 || y == 3'h6)) begin
        s4 = ~s4;
      end
    end
    sym_out = {s6, s4};
    // Running disparity carried to the next symbol
    if (stpe_ones(sym_out) == 4'h5) begin
      rd_out = rd_in;
    end else begin
      rd_out = (stpe_ones(sym_out) > 4'h5);
    end
  end

endmodule

`default_nettype wire

// >>> core/stpe_tx_top.sv
// Operation
// - Low select high sends control symbol, else data
// - High select high sends control symbol, else data
// - Whole word captured on reference clock rise
// - NRZ differential output, twenty bits per reference
// - Loopback high floats outputs, low drives them
// - Outputs float during power-on reset
`timescale 1ns/100ps
`default_nettype none

module stpe_tx_top
  import stpe_pkg::*;
(
  // Clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_n_in,
  // Parallel transmit side
  input  wire logic                   tx_ref_clk_in,
  input  wire logic [STPE_DATA_W-1:0] tx_data_in,
  input  wire logic                   low_byte_control_sel_in,
  input  wire logic                   high_byte_control_sel_in,
  // Mode pins
  input  wire logic                   loopback_enable_in,
  input  wire logic                   test_mode_enable_in,
  // Serial pair
  output logic                        serial_out_pos_out,
  output logic                        serial_out_neg_out,
  output logic                        serial_out_oe_out,
  // Status
  output logic                        ctrl_code_err_out
);

  // Input synchroniser state
  stpe_tx_word_t word_s1_reg;
  stpe_tx_word_t word_s1_next;
  stpe_tx_word_t word_s2_reg;
  stpe_tx_word_t word_s2_next;
  logic          ref_s1_reg;
  logic          ref_s1_next;
  logic          ref_s2_reg;
  logic          ref_s2_next;
  logic          ref_d_reg;
  logic          ref_d_next;
  logic          loop_s1_reg;
  logic          loop_s1_next;
  logic          loop_s2_reg;
  logic          loop_s2_next;
  logic          ref_rise;

  // Serializer state
  stpe_tx_word_t            hold_reg;
  stpe_tx_word_t            hold_next;
  logic [STPE_WORD_W-1:0]   shift_reg;
  logic [STPE_WORD_W-1:0]   shift_next;
  logic [4:0]               bit_cnt_reg;
  logic [4:0]               bit_cnt_next;
  logic                     rd_reg;
  logic                     rd_next;
  logic                     pos_reg;
  logic                     pos_next;
  logic                     neg_reg;
  logic                     neg_next;
  logic                     oe_reg;
  logic                     oe_next;
  logic                     err_reg;
  logic                     err_next;
  logic                     word_load;

  // Encoder results
  logic [STPE_SYM_W-1:0]    lo_sym;
  logic [STPE_SYM_W-1:0]    hi_sym;
  logic                     lo_rd;
  logic                     hi_rd;
  logic                     lo_bad;
  logic                     hi_bad;

  // Test mode is not implemented; the pin is accepted and ignored
  logic                     test_mode_unused;
  assign test_mode_unused = test_mode_enable_in;

  generate
    if (STPE_WORD_W != 2 * STPE_SYM_W) begin : g_bad_width
      $error("stpe_tx_top: word width must hold two symbols");
    end
  endgenerate

  // Pins come from another domain; the reference clock is sampled as data
  always_comb begin
    word_s1_next = '{hi_ctrl: high_byte_control_sel_in,
                     lo_ctrl: low_byte_control_sel_in,
                     data:    tx_data_in};
    word_s2_next = word_s1_reg;
    ref_s1_next  = tx_ref_clk_in;
    ref_s2_next  = ref_s1_reg;
    ref_d_next   = ref_s2_reg;
    loop_s1_next = loopback_enable_in;
    loop_s2_next = loop_s1_reg;
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      word_s1_reg <= STPE_WORD_RESET;
      word_s2_reg <= STPE_WORD_RESET;
      ref_s1_reg  <= 1'b0;
      ref_s2_reg  <= 1'b0;
      ref_d_reg   <= 1'b0;
      loop_s1_reg <= 1'b0;
      loop_s2_reg <= 1'b0;
    end else begin
      word_s1_reg <= word_s1_next;
      word_s2_reg <= word_s2_next;
      ref_s1_reg  <= ref_s1_next;
      ref_s2_reg  <= ref_s2_next;
      ref_d_reg   <= ref_d_next;
      loop_s1_reg <= loop_s1_next;
      loop_s2_reg <= loop_s2_next;
    end
  end

  // Word and its selects share the synchroniser delay, so they stay aligned
  assign ref_rise  = ref_s2_reg && !ref_d_reg;
  assign word_load = (bit_cnt_reg == STPE_BIT_LAST);

  stpe_enc8b10b u_enc_lo (
    .byte_in      (hold_reg.data[7:0]),
    .ctrl_in      (hold_reg.lo_ctrl),
    .rd_in        (rd_reg),
    .sym_out      (lo_sym),
    .rd_out       (lo_rd),
    .ctrl_bad_out (lo_bad)
  );

  stpe_enc8b10b u_enc_hi (
    .byte_in      (hold_reg.data[15:8]),
    .ctrl_in      (hold_reg.hi_ctrl),
    .rd_in        (lo_rd),
    .sym_out      (hi_sym),
    .rd_out       (hi_rd),
    .ctrl_bad_out (hi_bad)
  );

  always_comb begin
    hold_next    = hold_reg;
    shift_next   = {shift_reg[STPE_WORD_W-2:0], STPE_BIT_IDLE};
    bit_cnt_next = bit_cnt_reg + 5'h01;
    rd_next      = rd_reg;
    err_next     = err_reg;
    if (ref_rise) begin
      hold_next = word_s2_reg;
    end
    // Counter free-runs: a word never waits, a late word is simply resent
    if (word_load) begin
      bit_cnt_next = STPE_BIT_FIRST;
      shift_next   = {lo_sym, hi_sym};
      rd_next      = hi_rd;
      err_next     = lo_bad || hi_bad;
    end
    oe_next  = !loop_s2_reg;
    pos_next = oe_next && shift_reg[STPE_WORD_W-1];
    neg_next = oe_next && !shift_reg[STPE_WORD_W-1];
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      hold_reg    <= STPE_WORD_RESET;
      shift_reg   <= '0;
      bit_cnt_reg <= STPE_BIT_FIRST;
      rd_reg      <= STPE_RD_RESET;
      err_reg     <= 1'b0;
      oe_reg      <= 1'b0;
      pos_reg     <= 1'b0;
      neg_reg     <= 1'b0;
    end else begin
      hold_reg    <= hold_next;
      shift_reg   <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      rd_reg      <= rd_next;
      err_reg     <= err_next;
      oe_reg      <= oe_next;
      pos_reg     <= pos_next;
      neg_reg     <= neg_next;
    end
  end

  assign serial_out_pos_out = pos_reg;
  assign serial_out_neg_out = neg_reg;
  assign serial_out_oe_out  = oe_reg;
  assign ctrl_code_err_out  = err_reg;

  a_loop_float_pair: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    loop_s2_reg |=> !serial_out_oe_out)
    else $error("pair driven while loopback is on");

  a_normal_drive_pair: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    !loop_s2_reg && rst_n_in |=> serial_out_oe_out)
    else $error("pair not driven outside loopback");

  a_reset_float_pair: assert property (
    @(posedge core_clk_in) disable iff (1'b0)
    !rst_n_in |=> !serial_out_oe_out)
    else $error("pair driven during reset");

  a_word_capture_edge: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    ref_rise |=> hold_reg == $past(word_s2_reg))
    else $error("word not captured on reference rise");

  a_word_period_twenty: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    word_load |=> !word_load [*8] ##1 !word_load [*8] ##1 !word_load [*3]
      ##1 word_load)
    else $error("word period is not twenty bits");

  a_pair_opposite_level: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    serial_out_oe_out |-> serial_out_pos_out != serial_out_neg_out)
    else $error("serial pair not differential");

  a_low_symbol_first: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    word_load |=> shift_reg[STPE_WORD_W-1:STPE_SYM_W] == $past(lo_sym)
      && $countones(shift_reg) inside {[8:12]})
    else $error("low symbol not first or unbalanced");

  a_low_comma_code: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    hold_reg.lo_ctrl && hold_reg.data[7:0] == 8'hBC |->
      lo_sym == (rd_reg ? 10'h305 : 10'h0FA))
    else $error("low control byte gave wrong symbol");

  a_high_data_code: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    !hold_reg.hi_ctrl && hold_reg.data[15:8] == 8'h00 |->
      hi_sym == (lo_rd ? 10'h18B : 10'h274))
    else $error("high data byte gave wrong symbol");

  a_never_stall_count: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    rst_n_in && $past(rst_n_in) && bit_cnt_reg != STPE_BIT_FIRST |->
      bit_cnt_reg == $past(bit_cnt_reg) + 5'h01)
    else $error("bit counter stalled");

endmodule

`default_nettype wire

// >>> bench/stpe_proto_dev.sv
`timescale 1ns/100ps
`default_nettype none

module stpe_proto_dev
  import stpe_pkg::*;
(
  // Bit clock
  input  wire logic    core_clk_in,
  // Parallel transmit side
  output logic          tx_ref_clk_out,
  output stpe_tx_word_t word_out
);
  stpe_tx_word_t q [$];
  logic [4:0]    phase_reg = 5'h00;

  initial begin
    tx_ref_clk_out = 1'b0;
    word_out       = STPE_WORD_RESET;
  end

  task automatic push(input stpe_tx_word_t w);
    q.push_back(w);
  endtask

  // Never gated, exactly twenty bit times per period
  always @(negedge core_clk_in) begin
    phase_reg <= (phase_reg == STPE_BIT_LAST) ? STPE_BIT_FIRST : phase_reg + 5'h01;
    if (phase_reg == STPE_BIT_FIRST) begin
      tx_ref_clk_out <= 1'b1;
    end
    if (phase_reg == 5'h0A) begin
      tx_ref_clk_out <= 1'b0;
      // Changed mid-period, so stable ten bit times either side of each rise
      if (q.size() > 0) begin
        word_out <= q.pop_front();
      end
    end
  end
endmodule

`default_nettype wire

// >>> bench/tb_stpe_tx_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_stpe_tx_top
  import stpe_pkg::*;
  ;
  logic          core_clk_in = 1'b0;
  logic          rst_n_in    = 1'b0;
  logic          loop_en     = 1'b0;
  logic          rec         = 1'b0;
  logic          tx_ref_clk;
  stpe_tx_word_t word;
  logic          pos;
  logic          neg;
  logic          oe;
  logic          err;
  logic          pos_q [$];
  logic          neg_q [$];
  logic          err_q [$];
  int            err_count = 0;
  int            n_tests   = 0;
  int            cycles    = 0;
  stpe_tx_word_t tv [7] = '{'{1'b0, 1'b1, 16'h00BC}, '{1'b1, 1'b0, 16'hBC00},
                            '{1'b1, 1'b1, 16'hFC1C}, '{1'b1, 1'b1, 16'hBC00},
                            '{1'b0, 1'b0, 16'h0000}, '{1'b1, 1'b1, 16'hBCBC},
                            '{1'b1, 1'b0, 16'hF700}};

  initial begin
    forever #20 core_clk_in = ~core_clk_in;
  end

  stpe_proto_dev stpe_proto_dev_inst (
    .core_clk_in    (core_clk_in),
    .tx_ref_clk_out (tx_ref_clk),
    .word_out       (word)
  );

  stpe_tx_top stpe_tx_top_inst (
    .core_clk_in              (core_clk_in),
    .rst_n_in                 (rst_n_in),
    .tx_ref_clk_in            (tx_ref_clk),
    .tx_data_in               (word.data),
    .low_byte_control_sel_in  (word.lo_ctrl),
    .high_byte_control_sel_in (word.hi_ctrl),
    .loopback_enable_in       (loop_en),
    .test_mode_enable_in      (1'b0),
    .serial_out_pos_out       (pos),
    .serial_out_neg_out       (neg),
    .serial_out_oe_out        (oe),
    .ctrl_code_err_out        (err)
  );

  task automatic close_out;
    $display("Checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check_w(input string what, input logic [19:0] exp, input logic [19:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_b(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Negative-disparity codes; only symbols whose positive form is the inverse
  function automatic logic [9:0] code_neg(input logic c, input logic [7:0] b);
    case ({c, b})
      9'h1BC:  return 10'h0FA;
      9'h11C:  return 10'h0F4;
      9'h1FC:  return 10'h0F8;
      9'h1F7:  return 10'h3A8;
      default: return 10'h274;
    endcase
  endfunction

  function automatic logic [19:0] word_at(input logic sel, input int i);
    logic [19:0] w;
    w = 20'h00000;
    for (int j = 0; j < 20; j++) begin
      w = {w[18:0], sel ? neg_q[i+j] : pos_q[i+j]};
    end
    return w;
  endfunction

  always @(negedge core_clk_in) begin
    if (rec && oe === 1'b1) begin
      pos_q.push_back(pos);
      neg_q.push_back(neg);
      err_q.push_back(err);
    end
  end

  // Whole run needs well under a thousand cycles
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    logic [19:0] e [7];
    logic        bad [7];
    logic        rd;
    logic [9:0]  lo;
    logic [9:0]  hi;
    int          k;
    rd = STPE_RD_RESET;
    foreach (tv[i]) begin
      lo = code_neg(tv[i].lo_ctrl, tv[i].data[7:0]);
      lo = rd ? ~lo : lo;
      rd = rd ^ ($countones(lo) != 5);
      hi = code_neg(tv[i].hi_ctrl, tv[i].data[15:8]);
      hi = rd ? ~hi : hi;
      rd = rd ^ ($countones(hi) != 5);
      e[i] = {lo, hi};
      bad[i] = (tv[i].lo_ctrl && code_neg(1'b1, tv[i].data[7:0]) == 10'h274) ||
               (tv[i].hi_ctrl && code_neg(1'b1, tv[i].data[15:8]) == 10'h274);
    end
    repeat (16) @(negedge core_clk_in);
    check_b("oe in reset", 1'b0, oe);
    rst_n_in = 1'b1;
    rec = 1'b1;
    foreach (tv[i]) stpe_proto_dev_inst.push(tv[i]);
    stpe_proto_dev_inst.push(STPE_WORD_RESET);
    k = 0;
    while (stpe_proto_dev_inst.q.size() > 0 && k < 400) begin
      @(negedge core_clk_in);
      k++;
    end
    repeat (80) @(negedge core_clk_in);
    rec = 1'b0;
    k = -1;
    for (int i = 0; i + 140 <= pos_q.size() && k < 0; i++) begin
      if (word_at(1'b0, i) === e[0]) k = i;
    end
    check_b("first word found", 1'b1, k >= 0);
    if (k >= 0) begin
      foreach (tv[i]) begin
        check_w("serial word", e[i], word_at(1'b0, k + 20 * i));
        check_w("negative line", ~e[i], word_at(1'b1, k + 20 * i));
        check_b("control error", bad[i], err_q[k + 20 * i + 10]);
      end
    end
    loop_en = 1'b1;
    repeat (4) @(negedge core_clk_in);
    check_b("oe in loopback", 1'b0, oe);
    loop_en = 1'b0;
    repeat (4) @(negedge core_clk_in);
    check_b("oe after loopback", 1'b1, oe);
    rst_n_in = 1'b0;
    repeat (2) @(negedge core_clk_in);
    check_b("oe in second reset", 1'b0, oe);
    close_out();
  end
endmodule

`default_nettype wire
